// ==== rtl/odl_combiner.sv ====
/*
  output delay timers for outputs 13..15 and relay, and six logical outputs.
  assumes status signals, sources and the config write port are on mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module odl_combiner
  import odl_pkg::*;
#(
  parameter int TickCycles = TICK_CYCLES
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic driveRunning,
  input wire logic [STATUS_W-1:0] statusIn,
  input wire logic [NUM_DELAY-1:0] delaySrc,
  input wire logic cfgWrEn,
  input wire logic [CFG_ADDR_W-1:0] cfgAddr,
  input wire logic [CFG_DATA_W-1:0] cfgData,
  output logic cfgAck,
  output logic cfgReject,
  output logic [NUM_DELAY-1:0] delayedOut,
  output logic [NUM_LOGIC-1:0] logicOut
);
  // ----------------------------------------------------------------
  // 0.1 s timebase
  // ----------------------------------------------------------------
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TickCycles - 1);
  logic [TICK_CNT_W-1:0] tickCnt_q;
  logic tick_q;
  wire tickWrap = tickCnt_q == TICK_LAST;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tickCnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tickCnt_q <= tickWrap ? '0 : tickCnt_q + 24'h000001;
      tick_q <= tickWrap;
    end
  end

  // ----------------------------------------------------------------
  // config decode
  // ----------------------------------------------------------------
  wire isDelay = cfgAddr < ADDR_OPA0;
  wire isOpA = cfgAddr >= ADDR_OPA0 && cfgAddr < ADDR_OPB0;
  wire isOpB = cfgAddr >= ADDR_OPB0 && cfgAddr < ADDR_OPER0;
  wire isOper = cfgAddr >= ADDR_OPER0 && cfgAddr <= ADDR_LAST;
  wire [1:0] delayCh = cfgAddr[2:1];
  wire delayIsOff = cfgAddr[0];
  wire [2:0] idxA = 3'(cfgAddr - ADDR_OPA0);
  wire [2:0] idxB = 3'(cfgAddr - ADDR_OPB0);
  wire [2:0] idxOp = 3'(cfgAddr - ADDR_OPER0);
  wire [SEL_W-1:0] selVal = cfgData[SEL_W-1:0];
  wire selHighZero = cfgData[CFG_DATA_W-1:SEL_W] == '0;
  wire selIsLogic = selVal >= LOG_CODE_FIRST && selVal <= LOG_CODE_LAST;
  wire selLegal = selHighZero && !selIsLogic;
  wire delayLegal = cfgData <= DELAY_MAX;
  wire operLegal = cfgData <= 16'(OPER_XOR);
  wire valueLegal = (isDelay && delayLegal) || ((isOpA || isOpB) && selLegal)
                    || (isOper && operLegal);
  wire accept = cfgWrEn && !driveRunning && valueLegal;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cfgAck <= 1'b0;
      cfgReject <= 1'b0;
    end else begin
      cfgAck <= accept;
      cfgReject <= cfgWrEn && !accept;
    end
  end

  // ----------------------------------------------------------------
  // delay timers
  // ----------------------------------------------------------------
  logic [DELAY_W-1:0] onDelay_q [NUM_DELAY];
  logic [DELAY_W-1:0] offDelay_q [NUM_DELAY];

  for (genvar d = 0; d < NUM_DELAY; d++) begin : gen_delay
    odl_delay_if dif ();
    wire wrOn = accept && isDelay && delayCh == 2'(d) && !delayIsOff;
    wire wrOff = accept && isDelay && delayCh == 2'(d) && delayIsOff;

    always_ff @(posedge mclk) begin
      if (!nrst) begin
        onDelay_q[d] <= DELAY_RST;
        offDelay_q[d] <= DELAY_RST;
      end else begin
        if (wrOn) begin
          onDelay_q[d] <= cfgData[DELAY_W-1:0];
        end
        if (wrOff) begin
          offDelay_q[d] <= cfgData[DELAY_W-1:0];
        end
      end
    end

    assign dif.src = delaySrc[d];
    assign dif.tick = tick_q;
    assign dif.onDelay = onDelay_q[d];
    assign dif.offDelay = offDelay_q[d];
    assign delayedOut[d] = dif.outLvl;

    odl_delay_timer u_timer (
      .mclk (mclk),
      .nrst (nrst),
      .dif (dif)
    );
  end

  // ----------------------------------------------------------------
  // logical outputs
  // ----------------------------------------------------------------
  logic [SEL_W-1:0] opA_q [NUM_LOGIC];
  logic [SEL_W-1:0] opB_q [NUM_LOGIC];
  odl_oper_t oper_q [NUM_LOGIC];
  logic [NUM_LOGIC-1:0] logic_q;
  wire [NUM_LOGIC-1:0] aBit;
  wire [NUM_LOGIC-1:0] bBit;

  for (genvar i = 0; i < NUM_LOGIC; i++) begin : gen_logic
    wire wrA = accept && isOpA && idxA == 3'(i);
    wire wrB = accept && isOpB && idxB == 3'(i);
    wire wrOp = accept && isOper && idxOp == 3'(i);
    wire res;

    assign aBit[i] = statusIn[opA_q[i]];
    assign bBit[i] = statusIn[opB_q[i]];
    assign res = oper_q[i] == OPER_AND ? aBit[i] & bBit[i] :
                 oper_q[i] == OPER_OR ? aBit[i] | bBit[i] :
                 aBit[i] ^ bBit[i];

    always_ff @(posedge mclk) begin
      if (!nrst) begin
        opA_q[i] <= SEL_RST;
        opB_q[i] <= SEL_RST;
        oper_q[i] <= OPER_RST;
        logic_q[i] <= 1'b0;
      end else begin
        if (wrA) begin
          opA_q[i] <= selVal;
        end
        if (wrB) begin
          opB_q[i] <= selVal;
        end
        if (wrOp) begin
          oper_q[i] <= odl_oper_t'(cfgData[1:0]);
        end
        logic_q[i] <= res;
      end
    end
  end

  assign logicOut = logic_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence sWriteOpA0;
    cfgWrEn && !driveRunning && cfgAddr == ADDR_OPA0 && selLegal;
  endsequence
  sequence sWriteOpB0;
    cfgWrEn && !driveRunning && cfgAddr == ADDR_OPB0 && selLegal;
  endsequence
  sequence sWriteOnDelay0;
    cfgWrEn && !driveRunning && cfgAddr == ADDR_DELAY0 && delayLegal;
  endsequence
  sequence sWriteOper0;
    cfgWrEn && !driveRunning && cfgAddr == ADDR_OPER0 && operLegal;
  endsequence

  a_logic_code_refused: assert property ((isOpA || isOpB) && cfgWrEn && selIsLogic
    |=> cfgReject && !cfgAck)
    else $error("selector took a logical output code");
  a_running_write_blocked: assert property (cfgWrEn && driveRunning |=> !cfgAck && cfgReject
    ##0 $stable(onDelay_q[0]))
    else $error("setting changed while drive running");
  a_and_combine: assert property (oper_q[0] == OPER_AND
    |=> logicOut[0] == $past(aBit[0] & bBit[0]))
    else $error("and operator wrong");
  a_or_combine: assert property (oper_q[1] == OPER_OR
    |=> logicOut[1] == $past(aBit[1] | bBit[1]))
    else $error("or operator wrong");
  a_xor_combine: assert property (oper_q[2] == OPER_XOR
    |=> logicOut[2] == $past(aBit[2] ^ bBit[2]))
    else $error("xor operator wrong");
  a_first_operand_set: assert property (sWriteOpA0 |=> opA_q[0] == $past(selVal) ##0 cfgAck)
    else $error("first operand not stored");
  a_second_operand_set: assert property (sWriteOpB0 |=> opB_q[0] == $past(selVal)
    && opA_q[0] == $past(opA_q[0]))
    else $error("second operand not independent");
  a_ack_reject_excl: assert property (!(cfgAck && cfgReject))
    else $error("write both accepted and refused");
  a_delay_range_refused: assert property (isDelay && cfgWrEn && !delayLegal
    |=> cfgReject && !cfgAck)
    else $error("out of range delay accepted");
  a_oper_code_refused: assert property (isOper && cfgWrEn && !operLegal
    |=> cfgReject && !cfgAck)
    else $error("unknown operator code accepted");
  a_sel_range_refused: assert property ((isOpA || isOpB) && cfgWrEn && !selHighZero
    |=> cfgReject && !cfgAck)
    else $error("selector beyond status set accepted");
  a_on_delay_set: assert property (sWriteOnDelay0
    |=> onDelay_q[0] == $past(cfgData[DELAY_W-1:0]) ##0 cfgAck)
    else $error("on-delay not stored");
  a_oper_set: assert property (sWriteOper0
    |=> oper_q[0] == odl_oper_t'($past(cfgData[1:0])) ##0 cfgAck)
    else $error("operator not stored");
endmodule
`default_nettype wire

// ==== rtl/odl_pkg.sv ====
/*
  constants, field layouts and types of the output delay and logic combiner.
  assumes a 125 mhz control clock and a 6-bit drive status signal code space.
*/
package odl_pkg;
  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int CFG_ADDR_W = 5;
  localparam int CFG_DATA_W = 16;
  localparam int DELAY_W = 10;
  localparam int SEL_W = 6;
  localparam int STATUS_W = 64;
  localparam int NUM_DELAY = 4;
  localparam int NUM_LOGIC = 6;
  localparam int TICK_CNT_W = 24;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int TICK_TIME_NS = 100000000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // parameter index map
  // ----------------------------------------------------------------
  localparam logic [CFG_ADDR_W-1:0] ADDR_DELAY0 = 5'h00;
  localparam logic [CFG_ADDR_W-1:0] ADDR_OPA0 = 5'h08;
  localparam logic [CFG_ADDR_W-1:0] ADDR_OPB0 = 5'h0e;
  localparam logic [CFG_ADDR_W-1:0] ADDR_OPER0 = 5'h14;
  localparam logic [CFG_ADDR_W-1:0] ADDR_LAST = 5'h19;

  // ----------------------------------------------------------------
  // value limits and codes
  // ----------------------------------------------------------------
  localparam logic [CFG_DATA_W-1:0] DELAY_MAX = 16'h03e8;
  localparam logic [SEL_W-1:0] LOG_CODE_FIRST = 6'h21;
  localparam logic [SEL_W-1:0] LOG_CODE_LAST = 6'h26;

  typedef enum logic [1:0] {
    OPER_AND = 2'b00,
    OPER_OR  = 2'b01,
    OPER_XOR = 2'b10
  } odl_oper_t;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DELAY_W-1:0] DELAY_RST = 10'h000;
  localparam logic [SEL_W-1:0] SEL_RST = 6'h00;
  localparam odl_oper_t OPER_RST = OPER_AND;
endpackage

// ==== rtl/odl_delay_if.sv ====
/*
  carrier between the combiner top and one on/off delay timer.
  assumes the owner drives source, tick and delays; the timer drives the level.
*/
`timescale 1ns/10ps
`default_nettype none
interface odl_delay_if;
  import odl_pkg::*;
  logic src;
  logic tick;
  logic [DELAY_W-1:0] onDelay;
  logic [DELAY_W-1:0] offDelay;
  logic outLvl;
  modport timer (input src, input tick, input onDelay, input offDelay, output outLvl);
  modport owner (output src, output tick, output onDelay, output offDelay, input outLvl);
endinterface
`default_nettype wire

// ==== rtl/odl_delay_timer.sv ====
/*
  one on/off delay timer counting shared 0.1 s ticks.
  assumes tick is a one-cycle pulse on mclk and nrst is synchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module odl_delay_timer
  import odl_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  odl_delay_if.timer dif
);
  // ----------------------------------------------------------------
  // delay counter
  // ----------------------------------------------------------------
  logic out_q;
  logic [DELAY_W-1:0] cnt_q;
  wire pending = dif.src != out_q;
  wire [DELAY_W-1:0] limit = dif.src ? dif.onDelay : dif.offDelay;
  wire reached = cnt_q >= limit;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      out_q <= 1'b0;
      cnt_q <= DELAY_RST;
    end else if (!pending) begin
      cnt_q <= DELAY_RST;
    end else if (reached) begin
      out_q <= dif.src;
      cnt_q <= DELAY_RST;
    end else if (dif.tick) begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  assign dif.outLvl = out_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_on_delay_hold: assert property (!out_q && dif.src && cnt_q < dif.onDelay |=> !out_q)
    else $error("output asserted before on-delay elapsed");
  a_off_delay_hold: assert property (out_q && !dif.src && cnt_q < dif.offDelay |=> out_q)
    else $error("output released before off-delay elapsed");
  a_zero_delay_follow: assert property (!out_q && dif.src && dif.onDelay == DELAY_RST
    |=> out_q)
    else $error("zero on-delay did not pass through in one cycle");
endmodule
`default_nettype wire

// ==== dv/odl_status_model.sv ====
/*
  partner model: drive status logic feeding the combiner's status bus.
  assumes one mclk domain; stir high asks for fresh status every cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module odl_status_model
  import odl_pkg::*;
(
  input wire logic mclk,
  input wire logic stir,
  output logic [STATUS_W-1:0] statusIn
);
  // status changes only just after an edge, like registered drive logic
  always @(posedge mclk) begin
    if (stir) begin
      statusIn <= {$urandom, $urandom};
    end
  end
  initial statusIn = 64'h0;
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
/*
  self-checking bench of the output delay and logic combiner.
  assumes a 125 mhz mclk and a short timebase (TickCycles of 4).
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import odl_pkg::*;
  localparam int TC = 4;
  logic mclk, nrst, driveRunning, cfgWrEn, stir, cfgAck, cfgReject;
  logic [STATUS_W-1:0] statusIn, prevSt;
  logic [NUM_DELAY-1:0] delaySrc, delayedOut;
  logic [NUM_LOGIC-1:0] logicOut, expL;
  logic [CFG_ADDR_W-1:0] cfgAddr;
  logic [CFG_DATA_W-1:0] cfgData;
  logic [SEL_W-1:0] selA [NUM_LOGIC];
  logic [SEL_W-1:0] selB [NUM_LOGIC];
  logic [1:0] opr [NUM_LOGIC];
  int n_mismatch, checked, cyc, onD, offD;

  odl_combiner #(.TickCycles(TC)) u_dut (.mclk(mclk), .nrst(nrst),
    .driveRunning(driveRunning), .statusIn(statusIn), .delaySrc(delaySrc),
    .cfgWrEn(cfgWrEn), .cfgAddr(cfgAddr), .cfgData(cfgData), .cfgAck(cfgAck),
    .cfgReject(cfgReject), .delayedOut(delayedOut), .logicOut(logicOut));
  odl_status_model u_model (.mclk(mclk), .stir(stir), .statusIn(statusIn));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic comb(logic x, logic y, logic [1:0] o);
    return (o == 2'h0) ? (x & y) : (o == 2'h1) ? (x | y) : (x ^ y);
  endfunction

  function automatic logic [SEL_W-1:0] pickSel();
    logic [SEL_W-1:0] s;
    s = 6'($urandom_range(63));
    while (s >= LOG_CODE_FIRST && s <= LOG_CODE_LAST) s = 6'($urandom_range(63));
    return s;
  endfunction

  task automatic wr(input logic [CFG_ADDR_W-1:0] a, input logic [CFG_DATA_W-1:0] v,
                    input logic ok);
    @(posedge mclk);
    cfgWrEn <= 1'b1;
    cfgAddr <= a;
    cfgData <= v;
    @(posedge mclk);
    cfgWrEn <= 1'b0;
    #1;
    `CHK("cfgAck", ok, cfgAck)
    `CHK("cfgReject", !ok, cfgReject)
  endtask

  // counts cycles from the source edge until the output follows it
  task automatic delayRun(input int d, input int n, input logic lvl);
    int k;
    k = 0;
    @(posedge mclk);
    delaySrc[d] <= lvl;
    #1;
    while (delayedOut[d] !== lvl && k < 100) begin
      @(posedge mclk);
      #1;
      k++;
    end
    `CHK("delay window", 1'b1, (n == 0) ? (k == 1) : (k >= (n-1)*TC+2 && k <= n*TC+2))
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    void'($urandom(87));
    {nrst, driveRunning, cfgWrEn, stir} = 4'h0;
    cfgAddr = 5'h00;
    cfgData = 16'h0000;
    delaySrc = 4'h0;
    n_mismatch = 0;
    checked = 0;
    cyc = 0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1;
    `CHK("delayedOut", 4'h0, delayedOut)
    wr(5'h00, DELAY_MAX, 1'b1);
    wr(5'h00, DELAY_MAX + 16'h0001, 1'b0);
    wr(5'h07, DELAY_MAX + 16'h0001, 1'b0);
    wr(ADDR_OPA0, {10'h000, LOG_CODE_FIRST}, 1'b0);
    wr(5'(ADDR_OPB0 + 5), {10'h000, LOG_CODE_LAST}, 1'b0);
    wr(ADDR_OPER0, 16'h0003, 1'b0);
    wr(ADDR_OPA0, 16'h0040, 1'b0);
    wr(5'h1a, 16'h0000, 1'b0);
    for (int i = 0; i < NUM_LOGIC; i++) begin
      selA[i] = (i == 0) ? 6'h20 : pickSel();
      selB[i] = (i == 0) ? 6'h27 : (i == 5) ? selA[i] : pickSel();
      opr[i] = 2'(i % 3);
      wr(5'(ADDR_OPA0 + i), {10'h000, selA[i]}, 1'b1);
      wr(5'(ADDR_OPB0 + i), {10'h000, selB[i]}, 1'b1);
      wr(5'(ADDR_OPER0 + i), {14'h0000, opr[i]}, 1'b1);
    end
    @(posedge mclk);
    driveRunning <= 1'b1;
    wr(ADDR_OPER0, 16'h0001, 1'b0);
    wr(5'h00, 16'h0001, 1'b0);
    stir <= 1'b1;
    for (int j = 0; j < 200; j++) begin
      @(posedge mclk);
      #1;
      for (int i = 0; i < NUM_LOGIC; i++) expL[i] = comb(prevSt[selA[i]], prevSt[selB[i]], opr[i]);
      if (j > 0) `CHK("logicOut", expL, logicOut)
      prevSt = statusIn;
    end
    stir <= 1'b0;
    driveRunning <= 1'b0;
    for (int d = 0; d < NUM_DELAY; d++) begin
      onD = (d == 0) ? 0 : $urandom_range(1, 6);
      offD = (d == 1) ? 0 : $urandom_range(1, 6);
      wr(5'(2 * d), 16'(onD), 1'b1);
      wr(5'(2 * d + 1), 16'(offD), 1'b1);
      delayRun(d, onD, 1'b1);
      delayRun(d, offD, 1'b0);
    end
    @(posedge mclk);
    delaySrc <= 4'h1;
    repeat (2) @(posedge mclk);
    #1;
    `CHK("delayedOut", 4'h1, delayedOut)
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    `CHK("delayedOut", 4'h0, delayedOut)
    `CHK("logicOut", 6'h00, logicOut)
    @(posedge mclk);
    nrst <= 1'b1;
    delaySrc <= 4'h0;
    wr(ADDR_OPER0, 16'h0002, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
